// ---- core/char_compare.sv ----
// Parallel comparators of received bytes against match characters
`timescale 1ns/1ps
module char_compare
  import stm_pkg::*;
#(
  parameter int unsigned N = NUM_CHARS
)
(
  // Received stream
  input  wire logic                  i_rx_valid,
  input  wire logic [CHAR_W-1:0]     i_rx_byte,
  // Comparator settings, enable above character
  input  wire logic [N-1:0][CHAR_W:0] i_chars,
  // One hit per comparator
  output logic      [N-1:0]           o_hit
);

  // ==========================================================
  // Comparators
  // Each byte is checked by all comparators at once, so two
  // enabled registers holding the same character both report the hit
  for (genvar g = 0; g < N; g++)
  begin : g_cmp
    assign o_hit[g] = i_rx_valid
                    & i_chars[g][CHAR_EN_BIT]
                    & (i_chars[g][CHAR_W-1:0] == i_rx_byte);
  end

endmodule

// ---- core/serial_timer_and_char_match.sv ----
// Shared interval timer and received character match registers
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module serial_timer_and_char_match
  import stm_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // Register port
  input  wire logic [stm_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [stm_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [stm_pkg::DATA_W-1:0] o_rdata,
  // Serial core side
  input  wire logic                  i_ext_clk,
  input  wire logic                  i_rx_valid,
  input  wire logic [stm_pkg::CHAR_W-1:0] i_rx_byte,
  // Status and interrupt
  output logic                       o_tx_s7_set,
  output logic                       o_irq
);
  import stm_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic                          ext_prev;
    logic [ACC_W-1:0]              acc;
    logic                          sel;
    logic [TMR_VAL_W-1:0]          init;
    logic [TMR_VAL_W-1:0]          count;
    logic [NUM_CHARS-1:0][CHAR_W:0] chars;
    logic [NUM_CHARS-1:0]          detect;
    logic                          tflag;
    logic [3:0]                    mask;
    logic [DATA_W-1:0]             rdata;
    logic                          irq;
    logic                          s7;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [NUM_CHARS-1:0] hit;
  logic [ACC_W:0]       acc_sum;
  logic                 ref_tick;
  logic                 ext_rise;
  logic                 tick;
  logic                 wr_timer;
  logic                 wr_detect;
  logic                 clr_zero;

  // ==========================================================
  // Character comparators
  // One set of comparators watches the single shared stream;
  // channel A and B bytes are not told apart here
  char_compare #(
    .N (NUM_CHARS)
  ) u_cmp (
    .i_rx_valid (i_rx_valid),
    .i_rx_byte  (i_rx_byte),
    .i_chars    (state_reg.chars),
    .o_hit      (hit)
  );

  // ==========================================================
  // Tick sources
  // Fractional accumulator gives the reference rate on average;
  // single ticks jitter by one clock, fine for 1 us granularity
  assign acc_sum  = {1'b0, state_reg.acc} + ACC_INC;
  assign ref_tick = (acc_sum >= ACC_MOD);
  // External clock is taken as synchronous; edge by last sample
  assign ext_rise = i_ext_clk & ~state_reg.ext_prev;
  assign tick     = state_reg.sel ? ext_rise
                                  : ref_tick;
  assign wr_timer  = i_wr & (i_addr == TIMER_OFF);
  assign wr_detect = i_wr & (i_addr == DETECT_OFF);
  assign clr_zero  = i_wr & (i_addr == TFLAG_OFF) & i_wdata[TFLAG_BIT];

  // ==========================================================
  // Next state
  always_comb
  begin
    state_next          = state_reg;
    state_next.ext_prev = i_ext_clk;
    state_next.s7       = 1'b0;
    state_next.rdata    = '0;
    if (ref_tick)
    begin
      state_next.acc = ACC_W'(acc_sum - ACC_MOD);
    end
    else
    begin
      state_next.acc = ACC_W'(acc_sum);
    end

    // Timer: a write restarts the count, else tick down to zero
    if (wr_timer)
    begin
      state_next.sel   = i_wdata[TMR_SEL_BIT];
      state_next.init  = i_wdata[TMR_VAL_W-1:0];
      state_next.count = i_wdata[TMR_VAL_W-1:0];
    end
    else if (tick && state_reg.count != '0)
    begin
      state_next.count = state_reg.count - 1'b1;
      if (state_reg.count == 8'h01)
      begin
        state_next.s7 = 1'b1;
      end
    end

    // Match character registers
    for (int i = 0; i < NUM_CHARS; i++)
    begin
      if (i_wr && i_addr == CHAR1_OFF + 8'(i * 16))
      begin
        state_next.chars[i] = i_wdata[CHAR_W:0];
      end
    end

    // Sticky flags: write one clears, a new event wins
    if (wr_detect)
    begin
      state_next.detect = state_reg.detect
                        & ~i_wdata[NUM_CHARS-1:0];
    end
    state_next.detect = state_next.detect | hit;
    if (clr_zero)
    begin
      state_next.tflag = 1'b0;
    end
    if (state_next.s7)
    begin
      state_next.tflag = 1'b1;
    end
    if (i_wr && i_addr == MASK_OFF)
    begin
      state_next.mask = i_wdata[3:0];
    end

    // Interrupt from flags as they stand after this edge
    state_next.irq = |(state_next.detect
                       & state_next.mask[NUM_CHARS-1:0])
                   | (state_next.tflag & state_next.mask[MASK_TMR_BIT]);

    // Read data, present in the cycle after the strobe only
    if (i_rd)
    begin
      unique case (i_addr)
        TIMER_OFF:
        begin
          state_next.rdata[TMR_SEL_BIT] = state_reg.sel;
          // Live count only with the external source
          state_next.rdata[TMR_VAL_W-1:0] =
            state_reg.sel ? state_reg.count : state_reg.init;
        end
        CHAR1_OFF:  state_next.rdata[CHAR_W:0] = state_reg.chars[0];
        CHAR2_OFF:  state_next.rdata[CHAR_W:0] = state_reg.chars[1];
        CHAR3_OFF:  state_next.rdata[CHAR_W:0] = state_reg.chars[2];
        DETECT_OFF: state_next.rdata[NUM_CHARS-1:0] = state_reg.detect;
        TFLAG_OFF:  state_next.rdata[TFLAG_BIT] = state_reg.tflag;
        MASK_OFF:   state_next.rdata[3:0] = state_reg.mask;
        default:    state_next.rdata = '0;
      endcase
    end

    if (i_rst)
    begin
      state_next       = '0;
      state_next.count = COUNT_RST;
      state_next.chars = {NUM_CHARS{CHAR_RST}};
      state_next.detect = DETECT_RST;
      state_next.mask  = MASK_RST;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk)
  begin
    state_reg <= state_next;
  end

  // Outputs straight from flops
  assign o_rdata     = state_reg.rdata;
  assign o_tx_s7_set = state_reg.s7;
  assign o_irq       = state_reg.irq;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  timer_load_a: assert property (
    wr_timer |=> state_reg.count == $past(i_wdata[7:0]))
    else $error("timer did not load written count");

  ext_decrement_a: assert property (
    (state_reg.sel && ext_rise && !wr_timer && state_reg.count != 0)
    |=> state_reg.count == $past(state_reg.count) - 8'h01)
    else $error("external edge did not decrement");

  ref_decrement_a: assert property (
    (!state_reg.sel && ref_tick && !wr_timer && state_reg.count != 0)
    |=> state_reg.count == $past(state_reg.count) - 8'h01)
    else $error("reference tick did not decrement");

  live_read_a: assert property (
    (i_rd && i_addr == TIMER_OFF && state_reg.sel)
    |=> o_rdata[7:0] == $past(state_reg.count))
    else $error("timer read not live count");

  zero_status_a: assert property (
    (state_reg.count == 8'h01 && tick && !wr_timer)
    |=> o_tx_s7_set && state_reg.count == 8'h00 ##1 !o_tx_s7_set)
    else $error("zero did not pulse status bit 7");

  match_flag_a: assert property (
    hit[1] |=> state_reg.detect[1])
    else $error("match did not set detect flag");

  enable_gate_a: assert property (
    $rose(state_reg.detect[0]) |-> $past(i_rx_valid
      && state_reg.chars[0][8] && i_rx_byte == state_reg.chars[0][7:0]))
    else $error("flag set without enabled match");

  detect_irq_a: assert property (
    (|(state_reg.detect & state_reg.mask[2:0])) |-> o_irq)
    else $error("detect flag without interrupt");

  zero_hold_a: assert property (
    (state_reg.count == 0 && !wr_timer) |=> state_reg.count == 0)
    else $error("counter wrapped below zero");

  flag_sticky_a: assert property (
    (state_reg.detect[2] && !(wr_detect && i_wdata[2]))
    |=> state_reg.detect[2])
    else $error("detect flag cleared without write");

  // ==========================================================
  // Further checks on the read path, register writes, the count, the comparators, the zero event and the
  // interrupt; these catch a stray pulse or a stale read word
  // that the directed tests would only see by luck

  rdata_idle_a: assert property (
    !$past(i_rd) |-> o_rdata == '0)
    else $error("read data present without a read");

  static_read_a: assert property (
    (i_rd && i_addr == TIMER_OFF && !state_reg.sel)
    |=> o_rdata[7:0] == $past(state_reg.init))
    else $error("timer read not written value");

  sel_load_a: assert property (
    wr_timer
    |=> state_reg.sel == $past(i_wdata[TMR_SEL_BIT]))
    else $error("clock select did not take write");

  tick_only_a: assert property (
    (!tick && !wr_timer)
    |=> state_reg.count == $past(state_reg.count))
    else $error("count moved without a tick");

  char_write_a: assert property (
    (i_wr && i_addr == CHAR2_OFF)
    |=> state_reg.chars[1] == $past(i_wdata[CHAR_W:0]))
    else $error("match register did not take write");

  disabled_cmp_a: assert property (
    !state_reg.chars[2][CHAR_EN_BIT] |-> !hit[2])
    else $error("disabled comparator reported a hit");

  s7_cause_a: assert property (
    o_tx_s7_set |-> $past(state_reg.count == 8'h01 && tick && !wr_timer))
    else $error("status pulse without count reaching zero");

  tflag_set_a: assert property (
    o_tx_s7_set |-> state_reg.tflag)
    else $error("zero event did not set timer flag");

  write_wins_a: assert property (
    wr_timer |=> !o_tx_s7_set)
    else $error("status pulse in timer write cycle");

  detect_clear_a: assert property (
    (wr_detect && i_wdata[0] && !hit[0]) |=> !state_reg.detect[0])
    else $error("detect flag not cleared by write");

  irq_source_a: assert property (
    o_irq |-> (|(state_reg.detect & state_reg.mask[2:0]))
              || (state_reg.tflag && state_reg.mask[MASK_TMR_BIT]))
    else $error("interrupt without an enabled flag");

  irq_quiet_a: assert property (
    (state_reg.detect == '0 && !state_reg.tflag) |-> !o_irq)
    else $error("interrupt with every flag clear");

  // Cover points for the main scenarios
  timer_expiry_c: cover property (
    wr_timer ##[1:20] o_tx_s7_set);
  match_irq_c: cover property (hit[0] ##1 o_irq);
  set_clear_c: cover property (wr_detect && i_wdata[1] && hit[1]);
  ref_expiry_c: cover property (!state_reg.sel && o_tx_s7_set);
  timer_irq_c: cover property (o_tx_s7_set && o_irq);

endmodule

// ---- core/stm_pkg.sv ----
// Constants shared by the serial timer and character match block
package stm_pkg;

  // ==========================================================
  // Register map (byte addresses)
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam logic [7:0]  TIMER_OFF  = 8'ha0;
  localparam logic [7:0]  CHAR1_OFF  = 8'hb0;
  localparam logic [7:0]  CHAR2_OFF  = 8'hc0;
  localparam logic [7:0]  CHAR3_OFF  = 8'hd0;
  localparam logic [7:0]  DETECT_OFF = 8'he0;
  localparam logic [7:0]  TFLAG_OFF  = 8'he4;
  localparam logic [7:0]  MASK_OFF   = 8'he8;

  // ==========================================================
  // Field positions
  localparam int unsigned TMR_SEL_BIT  = 16;
  localparam int unsigned TMR_VAL_W    = 8;
  localparam int unsigned CHAR_W       = 8;
  localparam int unsigned CHAR_EN_BIT  = 8;
  localparam int unsigned NUM_CHARS    = 3;
  localparam int unsigned MASK_TMR_BIT = 3;
  localparam int unsigned TFLAG_BIT    = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  COUNT_RST  = 8'h00;
  localparam logic [8:0]  CHAR_RST   = 9'h000;
  localparam logic [2:0]  DETECT_RST = 3'h0;
  localparam logic [3:0]  MASK_RST   = 4'h7;

  // ==========================================================
  // Timing: reference tick made by a phase accumulator
  localparam int unsigned CLK_HZ  = 25000000;
  localparam int unsigned REF_HZ  = 921600;
  localparam int unsigned ACC_W   = 25;
  localparam logic [ACC_W:0] ACC_MOD = (ACC_W + 1)'(CLK_HZ);
  localparam logic [ACC_W:0] ACC_INC = (ACC_W + 1)'(REF_HZ);

endpackage

// ---- dv/serial_core_model.sv ----
// Behavioural serial core: external clock and received byte stream
`timescale 1ns/1ps
module serial_core_model
(
  // Clock
  input  wire logic       i_clk,
  // Stream towards the block
  output logic            o_ext_clk,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_byte
);
  // ======================================================
  // Idle levels at time zero
  initial
  begin
    o_ext_clk  = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_byte  = 8'h00;
  end

  // One strobe per byte; lane inverted after so stale data is not reused
  task automatic send_byte(input logic [7:0] b);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_byte  <= b;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_byte  <= ~b;
  endtask

  // External clock rests low between bursts of pulses
  task automatic ext_pulses(input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_ext_clk <= 1'b1;
      @(posedge i_clk);
      o_ext_clk <= 1'b0;
    end
  endtask
endmodule

// ---- dv/testbench.sv ----
// Register-level testbench of the timer and character match block
`timescale 1ns/1ps
module testbench;
  import stm_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        ext_clk, rx_valid, o_tx_s7_set, o_irq;
  logic [7:0]  rx_byte;
  int          fails = 0;
  int          checks_done = 0;
  int          pulses = 0;
  int          cycles = 0;
  logic [7:0]  offs [3] = '{CHAR1_OFF, CHAR2_OFF, CHAR3_OFF};

  // ======================================================
  // Clock, timeout and zero-pulse monitor
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    if (o_tx_s7_set === 1'b1)
      pulses <= pulses + 1;
    if (cycles == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  serial_core_model u_core (
    .i_clk      (i_clk),
    .o_ext_clk  (ext_clk),
    .o_rx_valid (rx_valid),
    .o_rx_byte  (rx_byte)
  );

  serial_timer_and_char_match u_dut (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_addr      (i_addr),
    .i_wdata     (i_wdata),
    .i_wr        (i_wr),
    .i_rd        (i_rd),
    .o_rdata     (o_rdata),
    .i_ext_clk   (ext_clk),
    .i_rx_valid  (rx_valid),
    .i_rx_byte   (rx_byte),
    .o_tx_s7_set (o_tx_s7_set),
    .o_irq       (o_irq)
  );

  // ======================================================
  // Bus tasks and comparison
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 chk($sformatf("reg %h", a), e, o_rdata);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ======================================================
  // Main sequence
  initial
  begin
    i_rst   <= 1'b1;
    i_addr  <= 8'h00;
    i_wdata <= 32'h0;
    i_wr    <= 1'b0;
    i_rd    <= 1'b0;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    // Reset values, unmapped place
    rd(TIMER_OFF, 32'h0);
    rd(DETECT_OFF, 32'h0);
    rd(MASK_OFF, 32'h7);
    wr(8'hf0, 32'hffff_ffff);
    rd(8'hf0, 32'h0);
    // Match registers keep nine bits, reserved read zero
    foreach (offs[i])
    begin
      rd(offs[i], 32'h0);
      wr(offs[i], 32'hffff_ffff);
      rd(offs[i], 32'h1ff);
    end
    wr(CHAR1_OFF, 32'h155);
    wr(CHAR2_OFF, 32'h1aa);
    wr(CHAR3_OFF, 32'h033);
    u_core.send_byte(8'h33);
    rd(DETECT_OFF, 32'h0);
    u_core.send_byte(8'h55);
    u_core.send_byte(8'haa);
    rd(DETECT_OFF, 32'h3);
    chk("irq", 1'b1, o_irq);
    wr(CHAR3_OFF, 32'h133);
    u_core.send_byte(8'h33);
    rd(DETECT_OFF, 32'h7);
    wr(DETECT_OFF, 32'h2);
    rd(DETECT_OFF, 32'h5);
    wr(DETECT_OFF, 32'h5);
    rd(DETECT_OFF, 32'h0);
    chk("irq", 1'b0, o_irq);
    // Masked detect keeps the flag but not the interrupt
    wr(MASK_OFF, 32'h8);
    u_core.send_byte(8'haa);
    rd(DETECT_OFF, 32'h2);
    chk("irq", 1'b0, o_irq);
    // Clear and new match in one cycle: the match wins
    fork
      wr(DETECT_OFF, 32'h2);
      u_core.send_byte(8'haa);
    join
    rd(DETECT_OFF, 32'h2);
    wr(DETECT_OFF, 32'h7);
    // External clock timer runs down, stops at zero
    wr(TIMER_OFF, 32'h0001_0003);
    u_core.ext_pulses(1);
    repeat (3) @(posedge i_clk);
    rd(TIMER_OFF, 32'h0001_0002);
    chk("pulses", 32'd0, pulses);
    u_core.ext_pulses(3);
    repeat (3) @(posedge i_clk);
    rd(TIMER_OFF, 32'h0001_0000);
    chk("pulses", 32'd1, pulses);
    chk("irq", 1'b1, o_irq);
    rd(TFLAG_OFF, 32'h1);
    wr(TFLAG_OFF, 32'h1);
    rd(TFLAG_OFF, 32'h0);
    chk("irq", 1'b0, o_irq);
    // Reference clock: two counts need two ticks of about 27 cycles
    wr(TIMER_OFF, 32'h2);
    rd(TIMER_OFF, 32'h2);
    repeat (18) @(posedge i_clk);
    chk("pulses", 32'd1, pulses);
    repeat (60) @(posedge i_clk);
    chk("pulses", 32'd2, pulses);
    rd(TIMER_OFF, 32'h2);
    // Reset in mid-run brings every register back to reset value
    u_core.send_byte(8'h55);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(CHAR1_OFF, 32'h0);
    rd(DETECT_OFF, 32'h0);
    rd(MASK_OFF, 32'h7);
    rd(TIMER_OFF, 32'h0);
    chk("irq", 1'b0, o_irq);
    complete_run();
  end
endmodule
